/* rtl/rss_sequencer.sv */
// Purpose: Reset and start-up sequencer with an AXI4-Lite register port.
// Assumes: Detector and pin inputs are asynchronous; watchdog and sleep are on CLK_SYS.
// Notes:   The delay timebase is CLK_SYS standing in for the internal RC clock.
`timescale 1ns/1ps
`default_nettype none
`include "rss_defines.svh"

module rss_sequencer #(
  parameter logic [`RSS_PUD_CW-1:0]  PUD_CYCLES  = `RSS_PUD_CW'(`RSS_PUD_CYC),
  parameter logic [`RSS_DROP_CW-1:0] DROP_CYCLES = `RSS_DROP_CW'(`RSS_DROP_CYC)
) (
  input  wire logic                   CLK_SYS,
  input  wire logic                   RESET,
  input  wire logic                   SUPPLY_RISE_DET,
  input  wire logic                   SUPPLY_DROP_DET,
  input  wire logic                   EXT_RESET_PIN_N,
  input  wire logic                   CRYSTAL_INPUT_PIN,
  input  wire logic                   WATCHDOG_EXPIRE,
  input  wire logic                   SLEEP_ACTIVE,
  output var  logic                   CORE_RESET,
  output var  logic                   CORE_HOLD,
  output var  logic                   CORE_RESUME,
  output var  logic                   EXEMPT_UNDEFINED,
  output var  rss_pkg::rss_cause_s    RESET_CAUSE,
  output var  logic                   WATCHDOG_EXPIRED_FLAG,
  output var  logic                   SLEEP_ENTERED_FLAG,
  input  wire logic [`RSS_ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                   S_AXI_AWVALID,
  output var  logic                   S_AXI_AWREADY,
  input  wire logic [`RSS_DATA_W-1:0] S_AXI_WDATA,
  input  wire logic [3:0]             S_AXI_WSTRB,
  input  wire logic                   S_AXI_WVALID,
  output var  logic                   S_AXI_WREADY,
  output var  logic [1:0]             S_AXI_BRESP,
  output var  logic                   S_AXI_BVALID,
  input  wire logic                   S_AXI_BREADY,
  input  wire logic [`RSS_ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                   S_AXI_ARVALID,
  output var  logic                   S_AXI_ARREADY,
  output var  logic [`RSS_DATA_W-1:0] S_AXI_RDATA,
  output var  logic [1:0]             S_AXI_RRESP,
  output var  logic                   S_AXI_RVALID,
  input  wire logic                   S_AXI_RREADY
);

  localparam logic [`RSS_PUD_CW-1:0]    PUD_LAST    = PUD_CYCLES - `RSS_PUD_CW'(1);
  localparam logic [`RSS_SETTLE_CW-1:0] SETTLE_LAST = `RSS_SETTLE_CW'(`RSS_SETTLE_EDGES - 1);

  rss_pkg::rss_seq_s      r;
  rss_pkg::rss_seq_s      n;
  logic                   pin_low;
  logic                   rise_s;
  logic                   drop_s;
  logic                   xtal_s;
  logic                   rise_evt;
  logic                   xtal_edge;
  logic                   pin_evt;
  logic                   drop_long;
  logic                   sdr_en;
  logic                   pud_on;
  logic                   crystal;
  logic                   in_cold_seq;
  rss_pkg::rss_clk_mode_e mode;
  logic [`RSS_DATA_W-1:0] status_word;
  logic [`RSS_DATA_W-1:0] rd_word;
  logic [1:0]             rd_resp;

  // Reset pin: synchronised and de-glitched; the device only listens to it
  rss_pin_filter u_pin_filter (
    .clk_sys   (CLK_SYS),
    .reset     (RESET),
    .pin_raw_n (EXT_RESET_PIN_N),
    .pin_low   (pin_low)
  );

  // Decoded configuration and synced inputs
  always_comb begin
    rise_s      = r.sync2[0];
    drop_s      = r.sync2[1];
    xtal_s      = r.sync2[2];
    mode        = rss_pkg::rss_clk_mode_e'(r.cfg[`RSS_CFG_SRC +: 2]);
    crystal     = (mode != rss_pkg::RESISTOR_CAPACITOR_MODE);
    sdr_en      = r.cfg[`RSS_CFG_SDR_EN];
    pud_on      = ~r.cfg[`RSS_CFG_PUD_N] | sdr_en;
    rise_evt    = rise_s & ~r.rise_prev;
    xtal_edge   = xtal_s & ~r.xtal_prev;
    pin_evt     = pin_low & ~r.pin_prev;
    drop_long   = (r.drop_cnt == DROP_CYCLES);
    in_cold_seq = (r.state != rss_pkg::ST_RUN) & ~r.cause.wdog_wake;
  end

  // Status word seen by software
  always_comb begin
    status_word                                = '0;
    status_word[`RSS_ST_WDX]                   = r.wdx_flag;
    status_word[`RSS_ST_SLP]                   = r.slp_flag;
    status_word[`RSS_ST_CAUSE +: $bits(r.cause)] = r.cause;
    status_word[`RSS_ST_FSM +: $bits(r.state)]   = r.state;
  end

  // Read decode; unmapped words read zero with an error response
  always_comb begin
    rd_word = '0;
    rd_resp = `RSS_RESP_OKAY;
    if (S_AXI_ARADDR == `RSS_ADDR_CONFIG) begin
      rd_word[`RSS_CFG_W-1:0] = r.cfg;
    end else if (S_AXI_ARADDR == `RSS_ADDR_STATUS) begin
      rd_word = status_word;
    end else begin
      rd_resp = `RSS_RESP_SLVERR;
    end
  end

  // Next-state logic of sequencer and bus slave
  always_comb begin
    n           = r;
    n.sync1     = {CRYSTAL_INPUT_PIN, SUPPLY_DROP_DET, SUPPLY_RISE_DET};
    n.sync2     = r.sync1;
    n.rise_prev = rise_s;
    n.xtal_prev = xtal_s;
    n.pin_prev  = pin_low;
    n.resume    = 1'h0;

    // Drop duration: saturates so a long drop is seen once per episode
    if (drop_s & sdr_en) begin
      if (!drop_long) begin
        n.drop_cnt = r.drop_cnt + `RSS_DROP_CW'(1);
      end
    end else begin
      n.drop_cnt = '0;
    end

    // Timers and state walk
    unique case (r.state)
      rss_pkg::ST_RUN: begin
      end
      rss_pkg::ST_PULSE: begin
        n.state = rss_pkg::ST_RUN;
      end
      rss_pkg::ST_START: begin
        n.pud_cnt    = '0;
        n.settle_cnt = '0;
        if (pud_on) begin
          n.state = rss_pkg::ST_DELAY;
        end else if (crystal) begin
          n.state = rss_pkg::ST_SETTLE;
        end else begin
          n.state = rss_pkg::ST_RUN;
        end
      end
      rss_pkg::ST_DROP: begin
        n.pud_cnt = '0;
        if (!drop_s) begin
          n.state = rss_pkg::ST_DELAY;
        end
      end
      rss_pkg::ST_DELAY: begin
        n.pud_cnt = r.pud_cnt + `RSS_PUD_CW'(1);
        if (sdr_en & drop_s) begin
          n.state = rss_pkg::ST_DROP;
        end else if (r.pud_cnt == PUD_LAST) begin
          n.settle_cnt = '0;
          if (crystal & r.cause.supply_rise) begin
            n.state = rss_pkg::ST_SETTLE;
          end else begin
            n.state = rss_pkg::ST_RUN;
          end
        end
      end
      rss_pkg::ST_SETTLE: begin
        if (xtal_edge) begin
          n.settle_cnt = r.settle_cnt + `RSS_SETTLE_CW'(1);
          if (r.settle_cnt == SETTLE_LAST) begin
            n.state  = rss_pkg::ST_RUN;
            n.resume = r.cause.wdog_wake;
          end
        end
      end
    endcase

    // Reset causes by priority; each but a pin reset while running records the flags that identify it
    if (rise_evt) begin
      n.cause             = '0;
      n.cause.supply_rise = 1'h1;
      n.wdx_flag          = 1'h1;
      n.slp_flag          = 1'h1;
      n.cold              = 1'h1;
      n.state             = rss_pkg::ST_START;
    end else if (drop_long && r.state != rss_pkg::ST_DROP) begin
      n.cause             = '0;
      n.cause.supply_drop = 1'h1;
      n.wdx_flag          = 1'h1;
      n.slp_flag          = 1'h1;
      n.state             = rss_pkg::ST_DROP;
    end else if (pin_evt && !in_cold_seq) begin
      // A pin reset during a running delay only extends the hold
      n.cause = '0;
      n.state = rss_pkg::ST_PULSE;
      if (SLEEP_ACTIVE) begin
        n.cause.pin_asleep = 1'h1;
        n.wdx_flag         = 1'h1;
        n.slp_flag         = 1'h0;
      end else begin
        n.cause.pin_running = 1'h1;
      end
    end else if (WATCHDOG_EXPIRE && r.state == rss_pkg::ST_RUN) begin
      n.cause    = '0;
      n.wdx_flag = 1'h0;
      if (SLEEP_ACTIVE) begin
        n.cause.wdog_wake = 1'h1;
        n.slp_flag        = 1'h0;
        n.settle_cnt      = '0;
        if (crystal) begin
          n.state = rss_pkg::ST_SETTLE;
        end else begin
          n.resume = 1'h1;
        end
      end else begin
        n.cause.wdog_running = 1'h1;
        n.slp_flag           = 1'h1;
        n.state              = rss_pkg::ST_PULSE;
      end
    end

    // Merged core reset, registered so release is clean on CLK_SYS
    n.core_reset = pin_low
                 | ((n.state != rss_pkg::ST_RUN) & ~n.cause.wdog_wake);
    n.core_hold  = (n.state == rss_pkg::ST_SETTLE) & n.cause.wdog_wake;
    if (n.state == rss_pkg::ST_RUN) begin
      n.cold = 1'h0;
    end

    // Write channel: address and data taken in either order
    if (S_AXI_AWVALID && !r.aw_got && !r.bvalid) begin
      n.aw_got = 1'h1;
      n.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !r.w_got && !r.bvalid) begin
      n.w_got  = 1'h1;
      n.wdata  = S_AXI_WDATA;
      n.wstrb0 = S_AXI_WSTRB[0];
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      n.aw_got = 1'h0;
      n.w_got  = 1'h0;
      n.bvalid = 1'h1;
      n.bresp  = `RSS_RESP_OKAY;
      if (r.awaddr == `RSS_ADDR_CONFIG) begin
        if (r.wstrb0) begin
          n.cfg = r.wdata[`RSS_CFG_W-1:0];
        end
      end else if (r.awaddr != `RSS_ADDR_STATUS) begin
        n.bresp = `RSS_RESP_SLVERR; // Status is read-only; writes there are dropped
      end
    end else if (r.bvalid && S_AXI_BREADY) begin
      n.bvalid = 1'h0;
    end

    // Read channel: one read at a time, data captured at address handshake
    if (S_AXI_ARVALID && !r.rvalid) begin
      n.rvalid = 1'h1;
      n.rdata  = rd_word;
      n.rresp  = rd_resp;
    end else if (r.rvalid && S_AXI_RREADY) begin
      n.rvalid = 1'h0;
    end
  end

  // State register; reset behaves as a fresh supply rise
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      r                   <= '0;
      r.state             <= rss_pkg::ST_START;
      r.cause.supply_rise <= 1'h1;
      r.wdx_flag          <= 1'h1;
      r.slp_flag          <= 1'h1;
      r.core_reset        <= 1'h1;
      r.cold              <= 1'h1;
      r.cfg               <= `RSS_CFG_RESET;
    end else begin
      r <= n;
    end
  end

  // Outputs
  assign CORE_RESET            = r.core_reset;
  assign CORE_HOLD             = r.core_hold;
  assign CORE_RESUME           = r.resume;
  assign EXEMPT_UNDEFINED      = r.cold;
  assign RESET_CAUSE           = r.cause;
  assign WATCHDOG_EXPIRED_FLAG = r.wdx_flag;
  assign SLEEP_ENTERED_FLAG    = r.slp_flag;
  assign S_AXI_AWREADY         = ~r.aw_got & ~r.bvalid;
  assign S_AXI_WREADY          = ~r.w_got & ~r.bvalid;
  assign S_AXI_BVALID          = r.bvalid;
  assign S_AXI_BRESP           = r.bresp;
  assign S_AXI_ARREADY         = ~r.rvalid;
  assign S_AXI_RVALID          = r.rvalid;
  assign S_AXI_RDATA           = r.rdata;
  assign S_AXI_RRESP           = r.rresp;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  a_rise_sets_flags: assert property (rise_evt |=> r.wdx_flag && r.slp_flag && r.cause.supply_rise)
    else $error("supply rise did not set both flags");

  a_delay_holds_core: assert property (r.state == rss_pkg::ST_DELAY |-> CORE_RESET)
    else $error("core released during power-up delay");

  a_delay_ends_on_count: assert property (r.state == rss_pkg::ST_DELAY && r.pud_cnt == PUD_LAST
      && !(sdr_en && drop_s) && !rise_evt && !drop_long |=> r.state != rss_pkg::ST_DELAY)
    else $error("power-up delay overran its count");

  a_settle_not_rc: assert property (r.state == rss_pkg::ST_SETTLE |-> crystal)
    else $error("settle count running in resistor-capacitor mode");

  a_settle_exit_count: assert property (r.state == rss_pkg::ST_SETTLE && xtal_edge
      && r.settle_cnt == SETTLE_LAST && !rise_evt && !drop_long && !pin_evt
      |=> r.state == rss_pkg::ST_RUN)
    else $error("settle count did not end after its last edge");

  a_drop_enters_reset: assert property (drop_long && !rise_evt && r.state != rss_pkg::ST_DROP
      |=> r.state == rss_pkg::ST_DROP && r.cause.supply_drop ##1 CORE_RESET)
    else $error("long supply drop did not reset");

  a_drop_restarts: assert property (r.state == rss_pkg::ST_DELAY && drop_s && sdr_en
      && !rise_evt |=> r.state == rss_pkg::ST_DROP)
    else $error("drop during delay did not restart the sequence");

  a_drop_forces_delay: assert property (r.state == rss_pkg::ST_START && sdr_en && !rise_evt
      && !drop_long |=> r.state == rss_pkg::ST_DELAY)
    else $error("supply-drop enable did not force the power-up delay");

  a_wake_no_reset: assert property (r.state == rss_pkg::ST_SETTLE && r.cause.wdog_wake
      |-> CORE_RESET == $past(pin_low))
    else $error("watchdog wake-up reset the core");

endmodule : rss_sequencer
`default_nettype wire

/* rtl/rss_defines.svh */
// Purpose: Named constants of the reset and start-up sequencer.
// Assumes: 100 MHz system clock; AXI4-Lite register window of 16 bytes.
// Notes:   Times are kept in their own units; cycle counts derive from them.
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

// Clock period and timing figures
`define RSS_CLK_NS        10
`define RSS_PUD_MS        72
`define RSS_DROP_US       100
`define RSS_FILT_NS       200
`define RSS_SETTLE_EDGES  1024

// Least times round up to whole cycles
`define RSS_PUD_CYC    ((`RSS_PUD_MS * 1000000 + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_DROP_CYC   ((`RSS_DROP_US * 1000 + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_FILT_CYC   ((`RSS_FILT_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)

// Counter widths
`define RSS_PUD_CW     23
`define RSS_DROP_CW    14
`define RSS_SETTLE_CW  11
`define RSS_FILT_CW    5

// Register map (byte addresses) and bus widths
`define RSS_ADDR_W       4
`define RSS_DATA_W       32
`define RSS_ADDR_CONFIG  4'h0
`define RSS_ADDR_STATUS  4'h4

// Configuration register fields
`define RSS_CFG_W       8
`define RSS_CFG_SRC     0
`define RSS_CFG_PUD_N   3
`define RSS_CFG_SDR_EN  6
`define RSS_CFG_RESET   8'h4B

// Status register fields
`define RSS_ST_WDX    0
`define RSS_ST_SLP    1
`define RSS_ST_CAUSE  2
`define RSS_ST_FSM    8

// Bus responses
`define RSS_RESP_OKAY    2'h0
`define RSS_RESP_SLVERR  2'h2

`endif

/* rtl/rss_pkg.sv */
// Purpose: Types shared by the reset and start-up sequencer files.
// Assumes: rss_defines.svh supplies the counter, config and bus widths.
// Notes:   All module state travels as one packed struct per module.
`include "rss_defines.svh"

package rss_pkg;

  // Clock-source modes as coded by the two select bits
  typedef enum logic [1:0] {
    LOW_POWER_CRYSTAL_MODE = 2'h0,
    CRYSTAL_RESONATOR_MODE = 2'h1,
    HIGH_SPEED_CRYSTAL_MODE = 2'h2,
    RESISTOR_CAPACITOR_MODE = 2'h3
  } rss_clk_mode_e;

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_RUN    = 6'h01,
    ST_START  = 6'h02,
    ST_DROP   = 6'h04,
    ST_DELAY  = 6'h08,
    ST_SETTLE = 6'h10,
    ST_PULSE  = 6'h20
  } rss_state_e;

  // Last reset cause, one-hot
  typedef struct packed {
    logic supply_rise;
    logic pin_running;
    logic pin_asleep;
    logic wdog_running;
    logic wdog_wake;
    logic supply_drop;
  } rss_cause_s;

  // Pin filter state
  typedef struct packed {
    logic                    s1;
    logic                    s2;
    logic                    low;
    logic [`RSS_FILT_CW-1:0] cnt;
  } rss_filt_s;

  // Sequencer and bus slave state
  typedef struct packed {
    logic [2:0]                sync1;
    logic [2:0]                sync2;
    logic                      rise_prev;
    logic                      xtal_prev;
    logic                      pin_prev;
    rss_state_e                state;
    rss_cause_s                cause;
    logic                      wdx_flag;
    logic                      slp_flag;
    logic [`RSS_PUD_CW-1:0]    pud_cnt;
    logic [`RSS_DROP_CW-1:0]   drop_cnt;
    logic [`RSS_SETTLE_CW-1:0] settle_cnt;
    logic                      core_reset;
    logic                      core_hold;
    logic                      resume;
    logic                      cold;
    logic [`RSS_CFG_W-1:0]     cfg;
    logic                      aw_got;
    logic                      w_got;
    logic [`RSS_ADDR_W-1:0]    awaddr;
    logic [`RSS_DATA_W-1:0]    wdata;
    logic                      wstrb0;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      rvalid;
    logic [`RSS_DATA_W-1:0]    rdata;
    logic [1:0]                rresp;
  } rss_seq_s;

endpackage : rss_pkg

/* rtl/rss_pin_filter.sv */
// Purpose: Synchronise and de-glitch the external reset pin.
// Assumes: Pin is asynchronous and active low.
// Notes:   A level must hold for the full filter time before it is taken.
`timescale 1ns/1ps
`default_nettype none
`include "rss_defines.svh"

module rss_pin_filter (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic pin_raw_n,
  output var  logic pin_low
);

  localparam logic [`RSS_FILT_CW-1:0] FILT_LAST = `RSS_FILT_CW'(`RSS_FILT_CYC - 1);

  rss_pkg::rss_filt_s r;
  rss_pkg::rss_filt_s n;

  // Two-flop sync, then a run-length filter on the synced level
  always_comb begin
    n    = r;
    n.s1 = pin_raw_n;
    n.s2 = r.s1;
    if ((~r.s2) != r.low) begin
      n.cnt = r.cnt + `RSS_FILT_CW'(1);
      if (r.cnt == FILT_LAST) begin
        n.low = ~r.s2;
        n.cnt = '0;
      end
    end else begin
      n.cnt = '0; // Short pulse: restart, so noise never reaches the sequencer
    end
  end

  // State register; pin assumed released after reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r    <= '0;
      r.s1 <= 1'h1;
      r.s2 <= 1'h1;
    end else begin
      r <= n;
    end
  end

  assign pin_low = r.low;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_filter_full_run: assert property ($changed(r.low) |-> $past(r.cnt) == FILT_LAST)
    else $error("pin level taken before the filter time ran out");

endmodule : rss_pin_filter
`default_nettype wire

/* test/rss_far_side.sv */
// Purpose: Far-side model of supply monitor, reset pin and crystal.
// Assumes: Bench commands change just after CLK_SYS rising edges.
// Notes:   Crystal runs free, as a real oscillator would.
`timescale 1ns/1ps
`default_nettype none
module rss_far_side (
  input  wire logic clk_sys,
  input  wire logic rise_cmd,
  input  wire logic drop_cmd,
  input  wire logic pin_low_cmd,
  output var  logic rise_det,
  output var  logic drop_det,
  output var  logic pin_n,
  output var  logic xtal
);
  logic [1:0] div_reg;
  // Quiet levels from time zero: supply good, pin released
  initial {rise_det, drop_det, pin_n, div_reg} = 5'h04;
  // Levels follow commands; the pin is only ever read by the device
  always @(posedge clk_sys) begin
    rise_det <= rise_cmd;
    drop_det <= drop_cmd;
    pin_n    <= ~pin_low_cmd;
    div_reg  <= div_reg + 2'h1;
  end
  // External clock on the crystal input, a quarter of CLK_SYS
  assign xtal = div_reg[1];
endmodule : rss_far_side
`default_nettype wire

/* test/test_rss_sequencer.sv */
// Purpose: Self-checking bench of the reset and start-up sequencer.
// Assumes: Short delay counts; crystal at a quarter of CLK_SYS.
// Notes:   Outputs are sampled at falling edges, clear of update races.
`timescale 1ns/1ps
`default_nettype none
`include "rss_defines.svh"
module test_rss_sequencer;
  localparam int PUD = 50;
  logic        CLK_SYS, RESET, WATCHDOG_EXPIRE, SLEEP_ACTIVE, rise_c, drop_c, pin_c, r;
  logic        SUPPLY_RISE_DET, SUPPLY_DROP_DET, EXT_RESET_PIN_N, CRYSTAL_INPUT_PIN;
  logic        CORE_RESET, CORE_HOLD, CORE_RESUME, EXEMPT_UNDEFINED, S_AXI_AWVALID;
  logic        WATCHDOG_EXPIRED_FLAG, SLEEP_ENTERED_FLAG, S_AXI_AWREADY, S_AXI_RREADY;
  logic        S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID;
  logic        S_AXI_ARREADY, S_AXI_RVALID, aw, w, v;
  logic [3:0]  S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd_v, seed, d;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, resp;
  rss_pkg::rss_cause_s RESET_CAUSE;
  int          errors = 0, checks = 0, cyc = 0, n;
  logic [7:0]  cfg_t [4] = '{8'h00, 8'h0A, 8'h0B, 8'h4B};
  int          lo_t [4] = '{PUD + 4090, 4090, 1, PUD};

  rss_sequencer #(.PUD_CYCLES(`RSS_PUD_CW'(PUD)), .DROP_CYCLES(`RSS_DROP_CW'(8))) u_dut (
    .CLK_SYS, .RESET, .SUPPLY_RISE_DET, .SUPPLY_DROP_DET, .EXT_RESET_PIN_N,
    .CRYSTAL_INPUT_PIN, .WATCHDOG_EXPIRE, .SLEEP_ACTIVE, .CORE_RESET, .CORE_HOLD,
    .CORE_RESUME, .EXEMPT_UNDEFINED, .RESET_CAUSE, .WATCHDOG_EXPIRED_FLAG,
    .SLEEP_ENTERED_FLAG, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
    .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
  rss_far_side u_far (.clk_sys(CLK_SYS), .rise_cmd(rise_c), .drop_cmd(drop_c),
    .pin_low_cmd(pin_c), .rise_det(SUPPLY_RISE_DET), .drop_det(SUPPLY_DROP_DET),
    .pin_n(EXT_RESET_PIN_N), .xtal(CRYSTAL_INPUT_PIN));

  // 100 MHz clock
  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  // Cycle ceiling, well above the longest expected run
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chkr(input string nm, input int lo, input int hi, input int g);
    checks++;
    if (g < lo || g > hi) begin
      errors++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chkr

  // Config read-back: the low byte of the last word written with strobe 0
  function automatic logic [31:0] cfg_exp(input logic [31:0] wd);
    return {24'h0, wd[7:0]};
  endfunction : cfg_exp

  task automatic tk(input int k);
    repeat (k) @(posedge CLK_SYS);
  endtask : tk

  // Cause and both flags together
  task automatic st(input logic [5:0] c, input logic x, input logic s);
    @(negedge CLK_SYS);
    chk("cause", {26'h0, c}, {26'h0, RESET_CAUSE});
    chk("flags", {30'h0, x, s}, {30'h0, WATCHDOG_EXPIRED_FLAG, SLEEP_ENTERED_FLAG});
  endtask : st

  // Wait for reset to assert, then time how long it stands
  task automatic rel(input int lo, input int hi);
    n = 0;
    while (CORE_RESET !== 1'b1 && n < 20) begin
      @(negedge CLK_SYS);
      n++;
    end
    chk("reset seen", 32'h1, {31'h0, CORE_RESET});
    n = 0;
    do begin
      @(negedge CLK_SYS);
      n++;
    end while (CORE_RESET !== 1'b0 && n <= hi);
    chkr("reset time", lo, hi, n);
  endtask : rel

  // AXI4-Lite write; readiness is read at the falling edge before the taking edge
  task automatic wr(input logic [3:0] a, input logic [31:0] dt, input logic [3:0] s);
    @(posedge CLK_SYS);
    {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_WSTRB} <= {a, dt, s};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    do begin
      @(negedge CLK_SYS);
      {aw, w, v, resp} = {S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BRESP};
      @(posedge CLK_SYS);
      if (aw === 1'b1) S_AXI_AWVALID <= 1'b0;
      if (w === 1'b1) S_AXI_WVALID <= 1'b0;
    end while (v !== 1'b1);
    S_AXI_BREADY <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    do begin
      @(negedge CLK_SYS);
      {aw, v, rd_v, resp} = {S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RDATA, S_AXI_RRESP};
      @(posedge CLK_SYS);
      if (aw === 1'b1) S_AXI_ARVALID <= 1'b0;
    end while (v !== 1'b1);
    S_AXI_RREADY <= 1'b0;
  endtask : rd

  // Main sequence
  initial begin
    seed = 32'h5B4DF8A9;
    {RESET, WATCHDOG_EXPIRE, SLEEP_ACTIVE, rise_c, drop_c, pin_c} = 6'h20;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB, S_AXI_WDATA} = 44'h0;
    tk(20);
    RESET <= 1'b0;
    @(negedge CLK_SYS);
    chk("exempt", 32'h1, {31'h0, EXEMPT_UNDEFINED});
    rel(PUD, PUD + 12);
    chk("exempt", 32'h0, {31'h0, EXEMPT_UNDEFINED});
    rd(`RSS_ADDR_CONFIG);
    chk("config", 32'h4B, rd_v);
    rd(`RSS_ADDR_STATUS);
    chk("status", 32'h183, rd_v);
    rd(4'h8);
    chk("unmapped", {30'h0, `RSS_RESP_SLVERR}, {rd_v[29:0], resp});
    // Every clock-source code, random filler in the other bits
    for (int m = 0; m < 4; m++) begin
      d = $random(seed);
      d[1:0] = 2'(m);
      wr(`RSS_ADDR_CONFIG, d, 4'hF);
      rd(`RSS_ADDR_CONFIG);
      chk("config", cfg_exp(d), rd_v);
    end
    // Read-only, unmapped and strobe-less writes leave the config alone
    wr(`RSS_ADDR_STATUS, 32'hFF, 4'hF);
    chk("bresp", {30'h0, `RSS_RESP_OKAY}, {30'h0, resp});
    wr(4'hC, 32'hFF, 4'hF);
    chk("bresp", {30'h0, `RSS_RESP_SLVERR}, {30'h0, resp});
    wr(`RSS_ADDR_CONFIG, 32'hFF, 4'h0);
    rd(`RSS_ADDR_CONFIG);
    chk("config", cfg_exp(d), rd_v);
    // Supply rise in low-power crystal, high-speed crystal and resistor-capacitor modes, delay on and off
    for (int i = 0; i < 4; i++) begin
      wr(`RSS_ADDR_CONFIG, {24'h0, cfg_t[i]}, 4'hF);
      rise_c <= 1'b1;
      rel(lo_t[i], lo_t[i] + 80);
      st(6'h20, 1'b1, 1'b1);
      tk(1);
      rise_c <= 1'b0;
    end
    // Short pin glitch is ignored, a long one resets
    pin_c <= 1'b1;
    tk(1 + $unsigned($random(seed)) % 12);
    pin_c <= 1'b0;
    tk(30);
    @(negedge CLK_SYS);
    chk("core reset", 32'h0, {31'h0, CORE_RESET});
    tk(1);
    pin_c <= 1'b1;
    tk(40);
    st(6'h10, 1'b1, 1'b1);
    tk(1);
    pin_c <= 1'b0;
    rel(1, 40);
    // Pin held past the start-up timers, release starts the core
    tk(1);
    {pin_c, rise_c} <= 2'h3;
    tk(PUD + 60);
    @(negedge CLK_SYS);
    chk("core reset", 32'h1, {31'h0, CORE_RESET});
    tk(1);
    {pin_c, rise_c} <= 2'h0;
    rel(1, 40);
    // Watchdog while running, then pin while asleep
    tk(1);
    WATCHDOG_EXPIRE <= 1'b1;
    tk(1);
    WATCHDOG_EXPIRE <= 1'b0;
    rel(1, 3);
    st(6'h04, 1'b0, 1'b1);
    tk(1);
    {SLEEP_ACTIVE, pin_c} <= 2'h3;
    tk(40);
    st(6'h08, 1'b1, 1'b0);
    tk(1);
    pin_c <= 1'b0;
    rel(1, 40);
    // Watchdog wake in crystal mode: hold for the settle count, no reset
    wr(`RSS_ADDR_CONFIG, 32'h01, 4'hF);
    WATCHDOG_EXPIRE <= 1'b1;
    tk(1);
    WATCHDOG_EXPIRE <= 1'b0;
    {n, r} = '0;
    for (int k = 0; k < 5000 && CORE_RESUME !== 1'b1; k++) begin
      @(negedge CLK_SYS);
      n += int'(CORE_HOLD === 1'b1);
      r |= CORE_RESET;
    end
    chkr("hold time", 4080, 4170, n);
    chk("resume", 32'h1, {31'h0, CORE_RESUME});
    chk("core reset", 32'h0, {31'h0, r});
    st(6'h02, 1'b0, 1'b0);
    // Short drop is ignored; long drop, then a second drop inside the delay
    wr(`RSS_ADDR_CONFIG, 32'h43, 4'hF);
    {SLEEP_ACTIVE, drop_c} <= 2'h1;
    tk(3);
    drop_c <= 1'b0;
    tk(10);
    @(negedge CLK_SYS);
    chk("core reset", 32'h0, {31'h0, CORE_RESET});
    tk(1);
    drop_c <= 1'b1;
    tk(30);
    st(6'h01, 1'b1, 1'b1);
    tk(1);
    drop_c <= 1'b0;
    tk(20);
    drop_c <= 1'b1;
    tk(20);
    drop_c <= 1'b0;
    rel(PUD, PUD + 12);
    test_done();
  end
endmodule : test_rss_sequencer
`default_nettype wire
